// [core/cop_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface cop_link_if;
   logic [31:0] addr;
   logic mem_request_n;
   logic consecutive_access;
   logic instr_fetch_n;
   logic cop_instr_strobe_n;
   logic write_select;
   logic word_select;
   logic [31:0] instr;
   logic [31:0] rdata;
   logic rdata_valid;
   logic cop_absent;
   logic cop_busy;
   modport proc (
      output addr, mem_request_n, consecutive_access, instr_fetch_n,
      output cop_instr_strobe_n, write_select, word_select, instr,
      output rdata, rdata_valid,
      input cop_absent, cop_busy
   );
   modport cop (
      input addr, mem_request_n, consecutive_access, instr_fetch_n,
      input cop_instr_strobe_n, write_select, word_select, instr,
      input rdata, rdata_valid,
      output cop_absent, cop_busy
   );
endinterface
`default_nettype wire

// [core/cop_responder.sv]
`timescale 1ns/1ns
`default_nettype none
module cop_responder
   import cop_seq_pkg::*;
#(
   parameter logic [COPNUM_W-1:0] COP_ID = 4'h1
) (
   input wire logic i_core_clk,                // core clock
   input wire logic i_rst,                     // sync reset, high
   cop_link_if.cop link,                       // processor side
   input wire logic i_enable,                  // coprocessor present
   input wire logic i_op_ready,                // can commit a data op
   output logic o_op_valid,                    // data op committed pulse
   output logic [31:0] o_op_instr,             // committed instruction
   output logic o_rx_valid,                    // received word valid
   input wire logic i_rx_ready,                // user takes word
   output logic [DATA_W-1:0] o_rx_data         // received word
);
   cop_state_type state_reg;
   logic [COUNT_W:0] remain_reg;
   logic [COUNT_W:0] words;
   logic [$clog2(FIFO_DEPTH):0] fifo_count;
   logic [$clog2(FIFO_DEPTH):0] fifo_free;
   logic fifo_in_ready;
   logic mine;
   logic is_xfer;
   logic can_commit;
   logic offered;
   logic op_valid_reg;
   logic [31:0] op_instr_reg;

   assign offered = !link.cop_instr_strobe_n && state_reg == COP_IDLE;
   assign mine = i_enable && link.instr[COPNUM_LSB +: COPNUM_W] == COP_ID;
   assign is_xfer = link.instr[XFER_BIT];
   assign words = {1'b0, link.instr[COUNT_LSB +: COUNT_W]} + 1'b1;
   assign fifo_free = ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH) - fifo_count;
   // transfer waits until the buffer can hold every word [RULE_08]
   assign can_commit = is_xfer ? (fifo_free >= words && fifo_in_ready)
                               : i_op_ready;                    // [RULE_02]

   always_comb begin
      link.cop_absent = 1'b1;  // [RULE_03]
      link.cop_busy = 1'b1;
      if (offered && mine) begin
         link.cop_absent = 1'b0;          // [RULE_04]
         link.cop_busy = !can_commit;
      end else if (state_reg == COP_XFER) begin
         link.cop_absent = remain_reg == 1;  // [RULE_10]
         link.cop_busy = remain_reg == 1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_reg <= COP_IDLE;
         remain_reg <= '0;
      end else begin
         case (state_reg)
            COP_IDLE: begin
               if (offered && mine && can_commit && is_xfer) begin
                  state_reg <= COP_XFER;
                  remain_reg <= words;
               end
            end
            COP_XFER: begin
               remain_reg <= remain_reg - 1'b1;  // [RULE_09]
               if (remain_reg == 1) begin
                  state_reg <= COP_IDLE;
               end
            end
            default: state_reg <= COP_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         op_valid_reg <= 1'b0;
         op_instr_reg <= '0;
      end else begin
         op_valid_reg <= offered && mine && can_commit && !is_xfer;
         if (offered && mine) begin
            op_instr_reg <= link.instr;
         end
      end
   end

   assign o_op_valid = op_valid_reg;
   assign o_op_instr = op_instr_reg;

   // one word captured each transfer cycle [RULE_09]
   cop_rx_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) rx_fifo (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_in_valid(link.rdata_valid),
      .o_in_ready(fifo_in_ready),
      .i_in_data(link.rdata),
      .o_out_valid(o_rx_valid),
      .i_out_ready(i_rx_ready),
      .o_out_data(o_rx_data),
      .o_count(fifo_count)
   );
endmodule
`default_nettype wire

// [core/cop_rx_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module cop_rx_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic i_core_clk,              // core clock
   input wire logic i_rst,                   // sync reset, high
   input wire logic i_in_valid,              // push request
   output logic o_in_ready,                  // room for a word
   input wire logic [WIDTH-1:0] i_in_data,   // pushed word
   output logic o_out_valid,                 // word available
   input wire logic i_out_ready,             // pop request
   output logic [WIDTH-1:0] o_out_data,      // head word
   output logic [$clog2(DEPTH):0] o_count    // words held
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0] wr_ptr_reg;
   logic [PW:0] rd_ptr_reg;
   logic push;
   logic pop;

   assign o_count = wr_ptr_reg - rd_ptr_reg;
   assign o_in_ready = o_count != (PW+1)'(DEPTH);
   assign o_out_valid = o_count != '0;
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;
   assign o_out_data = mem[rd_ptr_reg[PW-1:0]];

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr_reg[PW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [core/cop_seq_pkg.sv]
// Contract
// RULE_01: first cycle fetches pc+8, strobe low
// RULE_02: coprocessor commits before lowering busy
// RULE_03: incapable coprocessor leaves absent, busy high
// RULE_04: not yet able: absent low, busy high
// RULE_05: processor busy-waits while absent low, busy high
// RULE_06: busy-wait: pc+8, idle, strobe low
// RULE_07: commit cycle requests memory; data op fetches pc+12
// RULE_08: transfer commit only when data can be taken
// RULE_09: one word per cycle at sequential rate
// RULE_10: coprocessor counts words, both high marks last
// RULE_11: address computed early, base written back during transfer
// RULE_12: word reads, incrementing, sequential except last
// RULE_13: absent and busy high means undefined trap
// RULE_14: sample handshake at strobe-low cycle end
package cop_seq_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam logic [31:0] PC_OFFER_OFS = 32'h0000_0008;
   localparam logic [31:0] PC_NEXT_OFS = 32'h0000_000c;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   // instruction fields seen by both ends
   localparam int XFER_BIT = 20;
   localparam int COUNT_LSB = 0;
   localparam int COUNT_W = 4;
   localparam int COPNUM_LSB = 8;
   localparam int COPNUM_W = 4;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [2:0] {
      SEQ_IDLE,
      SEQ_OFFER,
      SEQ_WAIT,
      SEQ_XFER,
      SEQ_FETCH
   } seq_state_type;
   typedef enum logic {
      COP_IDLE,
      COP_XFER
   } cop_state_type;
endpackage

// [core/cop_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module cop_sequencer
   import cop_seq_pkg::*;
(
   input wire logic i_core_clk,              // core clock
   input wire logic i_rst,                   // sync reset, high
   cop_link_if.proc link,                    // coprocessor side
   input wire logic i_start_valid,           // instruction request
   output logic o_start_ready,               // sequencer idle
   input wire logic [31:0] i_instr,          // coprocessor instruction
   input wire logic [31:0] i_pc,             // address of instruction
   input wire logic [31:0] i_base,           // base register value
   input wire logic [31:0] i_offset,         // address offset
   input wire logic [DATA_W-1:0] i_mem_rdata, // memory read data
   output logic o_done,                      // instruction finished pulse
   output logic o_undef,                     // undefined trap pulse
   output logic o_wb_valid,                  // base write-back pulse
   output logic [31:0] o_wb_addr             // written-back base
);
   seq_state_type state_reg;
   seq_state_type state_next;
   logic [31:0] instr_reg;
   logic [31:0] pc_reg;
   logic [31:0] base_reg;
   logic [31:0] offset_reg;
   logic [31:0] xfer_addr_reg;
   logic [31:0] addr_reg;
   logic [31:0] calc_addr;
   logic [DATA_W-1:0] rdata_reg;
   logic rdata_valid_reg;
   logic done_reg;
   logic undef_reg;
   logic wb_valid_reg;
   logic [31:0] wb_addr_reg;
   logic is_xfer;
   logic handshaking;
   logic commit;
   logic refused;
   logic last_xfer;

   assign is_xfer = instr_reg[XFER_BIT];
   assign calc_addr = base_reg + offset_reg;
   assign handshaking = state_reg == SEQ_OFFER || state_reg == SEQ_WAIT;
   // handshake lines judged at the edge ending each strobe-low cycle
   assign commit = handshaking && !link.cop_busy;                  // [RULE_14]
   assign refused = handshaking && link.cop_absent && link.cop_busy;
   assign last_xfer = state_reg == SEQ_XFER
                      && link.cop_absent && link.cop_busy;
   assign o_start_ready = state_reg == SEQ_IDLE;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SEQ_IDLE: begin
            if (i_start_valid) begin
               state_next = SEQ_OFFER;
            end
         end
         SEQ_OFFER, SEQ_WAIT: begin
            if (commit) begin
               // data op goes straight to the next fetch [RULE_07]
               state_next = is_xfer ? SEQ_XFER : SEQ_FETCH;
            end else if (refused) begin
               state_next = SEQ_IDLE;  // [RULE_13]
            end else begin
               state_next = SEQ_WAIT;  // [RULE_05]
            end
         end
         SEQ_XFER: begin
            if (last_xfer) begin
               state_next = SEQ_FETCH;  // [RULE_12]
            end
         end
         SEQ_FETCH: state_next = SEQ_IDLE;
         default: state_next = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_reg <= SEQ_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // request captured when accepted
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         instr_reg <= '0;
         pc_reg <= '0;
         base_reg <= '0;
         offset_reg <= '0;
      end else if (state_reg == SEQ_IDLE && i_start_valid) begin
         instr_reg <= i_instr;
         pc_reg <= i_pc;
         base_reg <= i_base;
         offset_reg <= i_offset;
      end
   end

   // transfer address formed in the first cycle only, held through busy-wait cycles
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         xfer_addr_reg <= '0;
      end else if (state_reg == SEQ_OFFER) begin
         xfer_addr_reg <= calc_addr;  // [RULE_11]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         addr_reg <= '0;
      end else begin
         case (state_reg)
            SEQ_IDLE: begin
               if (i_start_valid) begin
                  addr_reg <= i_pc + PC_OFFER_OFS;  // [RULE_01]
               end
            end
            SEQ_OFFER, SEQ_WAIT: begin
               if (commit && is_xfer) begin
                  addr_reg <= state_reg == SEQ_OFFER ? calc_addr
                                                     : xfer_addr_reg;
               end else if (commit) begin
                  addr_reg <= pc_reg + PC_NEXT_OFS;  // [RULE_07]
               end
               // otherwise the address stays at pc+8 [RULE_06]
            end
            SEQ_XFER: begin
               if (last_xfer) begin
                  addr_reg <= pc_reg + PC_NEXT_OFS;  // [RULE_12]
               end else begin
                  addr_reg <= addr_reg + WORD_STEP;  // [RULE_12]
               end
            end
            default: addr_reg <= addr_reg;
         endcase
      end
   end

   // base write-back follows each transfer cycle
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         wb_valid_reg <= 1'b0;
         wb_addr_reg <= '0;
      end else begin
         wb_valid_reg <= state_reg == SEQ_XFER;  // [RULE_11]
         if (state_reg == SEQ_XFER) begin
            wb_addr_reg <= addr_reg + WORD_STEP;
         end
      end
   end

   // read data passed on to the coprocessor a cycle later
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rdata_reg <= '0;
         rdata_valid_reg <= 1'b0;
      end else begin
         rdata_valid_reg <= state_reg == SEQ_XFER;  // [RULE_09]
         if (state_reg == SEQ_XFER) begin
            rdata_reg <= i_mem_rdata;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         done_reg <= 1'b0;
         undef_reg <= 1'b0;
      end else begin
         done_reg <= state_reg == SEQ_FETCH;
         undef_reg <= refused;  // [RULE_13]
      end
   end

   always_comb begin
      link.mem_request_n = 1'b1;
      link.consecutive_access = 1'b0;
      link.instr_fetch_n = 1'b1;
      link.cop_instr_strobe_n = 1'b1;
      link.write_select = 1'b0;
      link.word_select = 1'b1;
      case (state_reg)
         SEQ_OFFER: begin
            link.instr_fetch_n = 1'b0;       // [RULE_01]
            link.cop_instr_strobe_n = 1'b0;
            link.mem_request_n = link.cop_busy;  // [RULE_07]
         end
         SEQ_WAIT: begin
            link.cop_instr_strobe_n = 1'b0;  // [RULE_06]
            link.mem_request_n = link.cop_busy;  // [RULE_07]
         end
         SEQ_XFER: begin
            link.mem_request_n = 1'b0;       // [RULE_12]
            link.consecutive_access = !last_xfer;
         end
         SEQ_FETCH: begin
            link.mem_request_n = 1'b0;
            link.instr_fetch_n = 1'b0;
         end
         default: link.mem_request_n = 1'b1;
      endcase
   end

   assign link.addr = addr_reg;
   assign link.instr = instr_reg;
   assign link.rdata = rdata_reg;
   assign link.rdata_valid = rdata_valid_reg;
   assign o_done = done_reg;
   assign o_undef = undef_reg;
   assign o_wb_valid = wb_valid_reg;
   assign o_wb_addr = wb_addr_reg;
endmodule
`default_nettype wire

// [tb/cop_seq_props.sv]
`timescale 1ns/1ns
`default_nettype none
module cop_seq_props
   import cop_seq_pkg::*;
(
   input wire logic i_core_clk, // core clock
   input wire logic i_rst, // sync reset
   input wire logic [31:0] addr, // bus address
   input wire logic mem_request_n, // memory cycle low
   input wire logic consecutive_access, // sequential
   input wire logic instr_fetch_n, // opcode fetch low
   input wire logic cop_instr_strobe_n, // offer strobe low
   input wire logic write_select, // write high
   input wire logic word_select, // word high
   input wire logic [31:0] instr, // offered instruction
   input wire logic rdata_valid, // word to coprocessor
   input wire logic cop_absent, // absent line
   input wire logic cop_busy // busy line
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [31:0] offer_addr_reg;
   logic strobe_d_reg;
   always_ff @(posedge i_core_clk) begin
      strobe_d_reg <= i_rst | cop_instr_strobe_n;
   end
   // offer address, held through waits
   always_ff @(posedge i_core_clk) begin
      if (!cop_instr_strobe_n) begin
         offer_addr_reg <= addr;
      end
   end
   sequence offer_s;
      !cop_instr_strobe_n;
   endsequence
   sequence commit_s;
      offer_s ##0 !cop_busy;
   endsequence
   sequence xfer_s;
      cop_instr_strobe_n && instr_fetch_n && !mem_request_n;
   endsequence
   offer_first_a: assert property (offer_s ##0 strobe_d_reg |->
      !instr_fetch_n && !consecutive_access) else $error("offer cycle not a fetch");
   wait_hold_a: assert property (offer_s ##0 !strobe_d_reg |->
      instr_fetch_n && !consecutive_access && addr == offer_addr_reg)
      else $error("busy-wait cycle outputs wrong");
   wait_req_a: assert property (offer_s |-> mem_request_n == cop_busy)
      else $error("memory request does not follow busy");
   repeat_wait_a: assert property (offer_s ##0 !cop_absent && cop_busy |=>
      offer_s) else $error("busy-wait not repeated");
   wait_absent_a: assert property (offer_s ##0 !cop_absent && cop_busy |=>
      !cop_absent) else $error("absent line rose during busy-wait");
   trap_exit_a: assert property (offer_s ##0 cop_absent && cop_busy |=>
      cop_instr_strobe_n && mem_request_n) else $error("trap cycle not idle");
   data_next_a: assert property (commit_s ##0 !instr[XFER_BIT] |=>
      !instr_fetch_n && !mem_request_n && cop_instr_strobe_n && addr == offer_addr_reg + WORD_STEP)
      else $error("data op did not fetch next");
   xfer_first_a: assert property (commit_s ##0 instr[XFER_BIT] |=>
      xfer_s ##0 !write_select && word_select) else $error("transfer did not start");
   xfer_step_a: assert property (xfer_s ##0 !cop_busy |->
      consecutive_access ##1 xfer_s ##0 addr == $past(addr) + WORD_STEP)
      else $error("transfer step wrong");
   xfer_pair_a: assert property (xfer_s ##0 !cop_busy |-> !cop_absent)
      else $error("non-final transfer lines differ");
   xfer_last_a: assert property (xfer_s ##0 cop_absent && cop_busy |->
      !consecutive_access ##1 !instr_fetch_n && !mem_request_n
      && addr == offer_addr_reg + WORD_STEP) else $error("final transfer wrong");
   data_follow_a: assert property (xfer_s |=> rdata_valid)
      else $error("word not forwarded");
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
   import cop_seq_pkg::*;
   localparam logic [3:0] cop_id = 4'h1;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic start_valid = 1'b0;
   logic enable = 1'b1;
   logic op_ready = 1'b1;
   logic rx_ready = 1'b1;
   logic hold = 1'b0;
   logic [31:0] instr = 32'h0;
   logic [31:0] pc = 32'h0;
   logic [31:0] base = 32'h0;
   logic [31:0] offset = 32'h0;
   logic [31:0] mem_rdata;
   logic start_ready, done, undef, wb_valid, op_valid, rx_valid;
   logic [31:0] wb_addr, op_instr, rx_data;
   logic [31:0] exp_rx[$], exp_wb[$], exp_op[$], exp_end[$];
   int bad_count = 0;
   int tests_run = 0;
   cop_link_if link ();
   cop_sequencer cop_sequencer_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .link(link),
      .i_start_valid(start_valid), .o_start_ready(start_ready), .i_instr(instr), .i_pc(pc),
      .i_base(base), .i_offset(offset), .i_mem_rdata(mem_rdata), .o_done(done),
      .o_undef(undef), .o_wb_valid(wb_valid), .o_wb_addr(wb_addr));
   cop_responder #(.COP_ID(cop_id)) cop_responder_inst (.i_core_clk(i_core_clk),
      .i_rst(i_rst), .link(link), .i_enable(enable), .i_op_ready(op_ready),
      .o_op_valid(op_valid), .o_op_instr(op_instr), .o_rx_valid(rx_valid),
      .i_rx_ready(rx_ready), .o_rx_data(rx_data));
   cop_seq_props cop_seq_props_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .addr(link.addr), .mem_request_n(link.mem_request_n),
      .consecutive_access(link.consecutive_access), .instr_fetch_n(link.instr_fetch_n),
      .cop_instr_strobe_n(link.cop_instr_strobe_n), .write_select(link.write_select),
      .word_select(link.word_select), .instr(link.instr), .rdata_valid(link.rdata_valid),
      .cop_absent(link.cop_absent), .cop_busy(link.cop_busy));
   always #2 i_core_clk = ~i_core_clk;
   // memory answers in the same cycle as the address
   assign mem_rdata = ~link.addr ^ 32'h3c00_0000;
   always @(posedge i_core_clk) begin
      rx_ready <= !hold && ($urandom_range(1, 0) == 1);
      op_ready <= $urandom_range(3, 0) != 0;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic run(input logic [31:0] ins, input logic en);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] o;
      while (exp_end.size() != 0) @(negedge i_core_clk);
      b = $urandom & 32'hffff_fffc;
      o = ($urandom & 32'hff) << 2;
      a = b + o;
      if (!en || ins[11:8] != cop_id) begin
         exp_end.push_back(32'h0);
      end else begin
         exp_end.push_back(32'h1);
         if (!ins[XFER_BIT]) exp_op.push_back(ins);
         for (int i = 0; ins[XFER_BIT] && i <= ins[3:0]; i++) begin
            exp_rx.push_back(~(a + 4 * i) ^ 32'h3c00_0000);
            exp_wb.push_back(a + 4 * (i + 1));
         end
      end
      @(posedge i_core_clk);
      start_valid <= 1'b1;
      instr <= ins;
      enable <= en;
      base <= b;
      offset <= o;
      pc <= $urandom & 32'hffff_fffc;
      @(negedge i_core_clk);
      while (start_ready !== 1'b1) @(negedge i_core_clk);
      @(posedge i_core_clk);
      start_valid <= 1'b0;
   endtask
   always @(negedge i_core_clk) begin
      if (!i_rst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
         check(rx_data, exp_rx.size() > 0 ? exp_rx.pop_front() : ~rx_data);
      end
      if (!i_rst && wb_valid === 1'b1) begin
         check(wb_addr, exp_wb.size() > 0 ? exp_wb.pop_front() : ~wb_addr);
      end
      if (!i_rst && op_valid === 1'b1) begin
         check(op_instr, exp_op.size() ? exp_op.pop_front() : ~op_instr);
      end
      if (!i_rst && (done === 1'b1 || undef === 1'b1)) begin
         check({31'h0, done}, exp_end.size() ? exp_end.pop_front() : 32'h2);
      end
   end
   initial begin
      logic [31:0] ins;
      void'($urandom(82676));
      repeat (5) @(posedge i_core_clk);
      i_rst <= 1'b0;
      run(32'h0000_0100, 1'b1);
      run(32'h0010_0100, 1'b1);
      run(32'h0010_0101, 1'b0);
      run(32'h0000_0200, 1'b1);
      // fill the receive buffer, then offer a transfer it cannot take
      while (exp_rx.size() != 0) @(negedge i_core_clk);
      @(posedge i_core_clk);
      hold <= 1'b1;
      run(32'h0010_010f, 1'b1);
      run(32'h0010_010f, 1'b1);
      repeat (40) @(posedge i_core_clk);
      hold <= 1'b0;
      for (int k = 0; k < 60; k++) begin
         ins = $urandom & 32'h0010_0f0f;
         if ($urandom_range(3, 0) != 0) ins[11:8] = cop_id;
         run(ins, $urandom_range(7, 0) != 0);
      end
      while (exp_end.size() + exp_rx.size() != 0) @(negedge i_core_clk);
      check(32'(exp_wb.size() + exp_op.size()), 32'h0);
      results();
   end
   // about thirty times the expected run length
   initial begin
      #100000;
      bad_count++;
      results();
   end
endmodule
`default_nettype wire
